// ---- src/dspwm_timer.v ----
// 16-bit timer unit with phase-and-frequency-correct PWM and control register A.
// Assumes an APB master on sys_clk and port logic on the same clock for the pins.
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`include "dspwm_map.vh"

// How it works
// - Mode 8 or 9 selects dual-slope PWM.
// - Count up from zero to TOP, then down.
// - Non-inverting clears up-match, sets down-match.
// - Action two non-inverted, three inverted.
// - TOP from capture (8) or compare A (9).
// - Counter holds TOP for one tick.
// - Compares load at BOTTOM with overflow flag.
// - TOP source flag set on reaching TOP.
// - Match flag when count equals compare.
// - Pin driven only when direction is output.
// - Period is two times prescale times TOP.
// - Compare zero low, compare TOP high.
// - Mode 9 action one toggles channel A.
// - Control A field layout, all reset zero.
// - Actions two and three override the port pin; one only where it toggles.
// - Action decode depends on waveform mode.
// - Synchronous; timer tick is a clock enable.
// - Action zero disconnects; one toggles only A in 9/11, any channel in 0/4.
// - Mode bits join control A and B.
module dspwm_timer #(
  parameter WIDTH = 16
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Normal port values and the pins of channels A, B, C.
  input wire [2:0] portOut,
  output reg [2:0] waveformPinOut,
  output reg [2:0] waveformPinOe,
  // Waveform levels and timer tick for observation.
  output reg [2:0] waveformOutput,
  output reg timerTick
);

  reg [7:0] controlA;
  reg [7:0] controlB;
  reg [WIDTH-1:0] countValue;
  reg countDown;
  reg [WIDTH-1:0] captureTopValue;
  reg [WIDTH-1:0] bufA;
  reg [WIDTH-1:0] bufB;
  reg [WIDTH-1:0] bufC;
  reg [WIDTH-1:0] compareValueA;
  reg [WIDTH-1:0] compareValueB;
  reg [WIDTH-1:0] compareValueC;
  reg [4:0] flags;
  reg [2:0] pinDirectionBit;
  reg [10:0] prescaleCount;

  wire [3:0] waveformModeSelect;
  wire pfcMode;
  wire [WIDTH-1:0] topValue;
  wire atTop;
  wire atBottom;
  wire upPhase;
  wire [2:0] match;
  wire [5:0] actions;
  wire setupPhase;
  wire accessWrite;
  wire [4:0] flagSet;
  wire [4:0] flagClear;
  wire [2:0] pinWave;
  reg [10:0] divisor;
  reg [WIDTH-1:0] next_countValue;
  reg next_countDown;
  reg [2:0] next_waveformOutput;
  reg [2:0] connected;
  reg [31:0] readWord;
  reg readMiss;
  integer i;

  assign waveformModeSelect = {controlB[`DSPWM_MODE_HI_HI:`DSPWM_MODE_HI_LO],
    controlA[`DSPWM_MODE_LO_HI:0]};
  assign pfcMode = (waveformModeSelect == `DSPWM_MODE_PFC_CAP) ||
    (waveformModeSelect == `DSPWM_MODE_PFC_CMPA);
  assign topValue = (waveformModeSelect == `DSPWM_MODE_PFC_CAP) ?
    captureTopValue : compareValueA;
  assign atTop = (countValue == topValue);
  assign atBottom = (countValue == {WIDTH{1'b0}});
  // Bottom belongs to the rising slope and TOP to the falling one.
  assign upPhase = atBottom || (!countDown && !atTop);
  assign match[0] = (countValue == compareValueA);
  assign match[1] = (countValue == compareValueB);
  assign match[2] = (countValue == compareValueC);
  assign actions = controlA[`DSPWM_ACT_A_HI:`DSPWM_ACT_C_LO];

  // Prescaler producing the one-cycle timer tick.
  // A stopped or reserved clock select keeps the tick low and the divider cleared.
  always @*
  begin
    case (controlB[`DSPWM_PRE_HI:0])
      `DSPWM_PRE_8: divisor = `DSPWM_DIV_8;
      `DSPWM_PRE_64: divisor = `DSPWM_DIV_64;
      `DSPWM_PRE_256: divisor = `DSPWM_DIV_256;
      `DSPWM_PRE_1024: divisor = `DSPWM_DIV_1024;
      default: divisor = 11'h001;
    endcase
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      prescaleCount <= 11'h000;
      timerTick <= 1'b0;
    end
    else if (controlB[`DSPWM_PRE_HI:0] == `DSPWM_PRE_STOP ||
             controlB[`DSPWM_PRE_HI:0] > `DSPWM_PRE_1024)
    begin
      prescaleCount <= 11'h000;
      timerTick <= 1'b0;
    end
    else if (prescaleCount >= divisor - 11'h001)
    begin
      prescaleCount <= 11'h000;
      timerTick <= 1'b1;
    end
    else
    begin
      prescaleCount <= prescaleCount + 11'h001;
      timerTick <= 1'b0;
    end
  end

  // Counter sequence: dual slope in PWM mode, upward count otherwise, cleared on compare A match in CTC mode.
  // A count left above TOP on the rising slope keeps rising until it wraps, so software keeps TOP above it.
  always @*
  begin
    next_countValue = countValue;
    next_countDown = countDown;
    if (pfcMode)
    begin
      if (!countDown)
      begin
        if (atTop)
        begin
          next_countValue = countValue - {{(WIDTH-1){1'b0}}, 1'b1};
          next_countDown = 1'b1;
        end
        else
          next_countValue = countValue + {{(WIDTH-1){1'b0}}, 1'b1};
      end
      else if (atBottom)
      begin
        next_countValue = countValue + {{(WIDTH-1){1'b0}}, 1'b1};
        next_countDown = 1'b0;
      end
      else
        next_countValue = countValue - {{(WIDTH-1){1'b0}}, 1'b1};
    end
    else
    begin
      next_countDown = 1'b0;
      if (waveformModeSelect == `DSPWM_MODE_CTC && match[0])
        next_countValue = {WIDTH{1'b0}};
      else
        next_countValue = countValue + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Action decode per channel and mode.
  // Toggle, clear and set outside the PWM modes are kept minimal.
  always @*
  begin
    next_waveformOutput = waveformOutput;
    connected = 3'b000;
    for (i = 0; i < 3; i = i + 1)
    begin
      case (actions[5-2*i -: 2])
        `DSPWM_ACT_OFF: connected[i] = 1'b0;
        `DSPWM_ACT_TOGGLE:
        begin
          if (i == 0 && (waveformModeSelect == `DSPWM_MODE_PFC_CMPA ||
              waveformModeSelect == `DSPWM_MODE_PC_CMPA))
          begin
            connected[i] = 1'b1;
            if (match[i])
              next_waveformOutput[i] = !waveformOutput[i];
          end
          else if (!pfcMode && waveformModeSelect[3:2] == 2'b01 &&
                   waveformModeSelect[1:0] == 2'b00)
          begin
            connected[i] = 1'b1;
            if (match[i])
              next_waveformOutput[i] = !waveformOutput[i];
          end
          else if (waveformModeSelect == `DSPWM_MODE_NORMAL)
          begin
            connected[i] = 1'b1;
            if (match[i])
              next_waveformOutput[i] = !waveformOutput[i];
          end
          else
            connected[i] = 1'b0;
        end
        `DSPWM_ACT_NONINV:
        begin
          connected[i] = 1'b1;
          if (match[i])
            next_waveformOutput[i] = pfcMode ? !upPhase : 1'b0;
        end
        `DSPWM_ACT_INV:
        begin
          connected[i] = 1'b1;
          if (match[i])
            next_waveformOutput[i] = pfcMode ? upPhase : 1'b1;
        end
        default: connected[i] = 1'b0;
      endcase
    end
  end

  // Tick-enabled timer state and double-buffered compare registers.
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      countValue <= `DSPWM_WORD_RST;
      countDown <= 1'b0;
      compareValueA <= `DSPWM_WORD_RST;
      compareValueB <= `DSPWM_WORD_RST;
      compareValueC <= `DSPWM_WORD_RST;
      waveformOutput <= 3'b000;
    end
    else
    begin
      if (accessWrite && paddr == `DSPWM_COUNT)
        countValue <= pwdata[WIDTH-1:0];
      else if (timerTick)
      begin
        countValue <= next_countValue;
        countDown <= next_countDown;
      end
      if (timerTick)
        waveformOutput <= next_waveformOutput;
      // Outside the PWM modes the buffers pass straight through.
      if (!pfcMode)
      begin
        compareValueA <= bufA;
        compareValueB <= bufB;
        compareValueC <= bufC;
      end
      else if (timerTick && atBottom)
      begin
        compareValueA <= bufA;
        compareValueB <= bufB;
        compareValueC <= bufC;
      end
    end
  end

  // Sticky flags; software writes one to clear, and a set wins.
  // A zero written to a flag bit leaves it alone.
  assign flagSet[`DSPWM_FLAG_OVF] = timerTick &&
    (pfcMode ? atBottom : (countValue == {WIDTH{1'b1}}));
  assign flagSet[`DSPWM_FLAG_CMPA] = timerTick && match[0];
  assign flagSet[`DSPWM_FLAG_CMPB] = timerTick && match[1];
  assign flagSet[`DSPWM_FLAG_CMPC] = timerTick && match[2];
  assign flagSet[`DSPWM_FLAG_CAP] = timerTick && atTop &&
    (waveformModeSelect == `DSPWM_MODE_PFC_CAP);
  assign flagClear = (accessWrite && paddr == `DSPWM_FLAGS) ? pwdata[4:0] : 5'h00;

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      flags <= 5'h00;
    else
      flags <= (flags & ~flagClear) | flagSet;
  end

  // Pins: waveform overrides the port, direction bit enables the driver.
  // Between ticks a pending match must not reach the pin early, so the pin
  // follows the next level only on a tick and the current level otherwise.
  assign pinWave = timerTick ? next_waveformOutput : waveformOutput;

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      waveformPinOut <= 3'b000;
      waveformPinOe <= 3'b000;
    end
    else
    begin
      waveformPinOe <= pinDirectionBit;
      waveformPinOut <= (connected & pinWave) | (~connected & portOut);
    end
  end

  // APB slave: zero-wait access, read data captured in the setup cycle.
  // Writes to unmapped offsets are dropped, and accesses to them raise pslverr.
  assign setupPhase = psel && !penable;
  assign accessWrite = psel && penable && pwrite;
  assign pready = 1'b1;

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      controlA <= `DSPWM_CTRLA_RST;
      controlB <= `DSPWM_CTRLB_RST;
      captureTopValue <= `DSPWM_WORD_RST;
      bufA <= `DSPWM_WORD_RST;
      bufB <= `DSPWM_WORD_RST;
      bufC <= `DSPWM_WORD_RST;
      pinDirectionBit <= 3'b000;
    end
    else if (accessWrite)
    begin
      case (paddr)
        `DSPWM_CTRLA_U1: controlA <= pwdata[7:0];
        `DSPWM_CTRLB: controlB <= pwdata[7:0];
        `DSPWM_CAPTOP: captureTopValue <= pwdata[WIDTH-1:0];
        `DSPWM_CMPA: bufA <= pwdata[WIDTH-1:0];
        `DSPWM_CMPB: bufB <= pwdata[WIDTH-1:0];
        `DSPWM_CMPC: bufC <= pwdata[WIDTH-1:0];
        `DSPWM_PINDIR: pinDirectionBit <= pwdata[2:0];
        default: pinDirectionBit <= pinDirectionBit;
      endcase
    end
  end

  always @*
  begin
    readWord = 32'h00000000;
    readMiss = 1'b0;
    case (paddr)
      `DSPWM_CTRLA_U1: readWord[7:0] = controlA;
      `DSPWM_CTRLB: readWord[7:0] = controlB;
      `DSPWM_COUNT: readWord[WIDTH-1:0] = countValue;
      `DSPWM_CAPTOP: readWord[WIDTH-1:0] = captureTopValue;
      `DSPWM_CMPA: readWord[WIDTH-1:0] = bufA;
      `DSPWM_CMPB: readWord[WIDTH-1:0] = bufB;
      `DSPWM_CMPC: readWord[WIDTH-1:0] = bufC;
      `DSPWM_FLAGS: readWord[5:0] = {countDown, flags};
      `DSPWM_PINDIR: readWord[2:0] = pinDirectionBit;
      default: readMiss = 1'b1;
    endcase
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setupPhase)
    begin
      prdata <= pwrite ? 32'h00000000 : readWord;
      pslverr <= readMiss;
    end
  end

endmodule

// ---- src/dspwm_map.vh ----
// Register map, field positions, reset values and codes of the dual-slope PWM timer.
// Included by the timer module; holds definitions only.
`ifndef DSPWM_MAP_VH
`define DSPWM_MAP_VH

`define DSPWM_CTRLA_U1 12'h080
`define DSPWM_CTRLA_U3 12'h090
`define DSPWM_CTRLA_U4 12'h0a0
`define DSPWM_CTRLA_U5 12'h120
`define DSPWM_CTRLB 12'h040
`define DSPWM_COUNT 12'h044
`define DSPWM_CAPTOP 12'h048
`define DSPWM_CMPA 12'h04c
`define DSPWM_CMPB 12'h050
`define DSPWM_CMPC 12'h054
`define DSPWM_FLAGS 12'h058
`define DSPWM_PINDIR 12'h05c

`define DSPWM_CTRLA_RST 8'h00
`define DSPWM_CTRLB_RST 8'h00
`define DSPWM_WORD_RST 16'h0000

`define DSPWM_ACT_A_HI 7
`define DSPWM_ACT_A_LO 6
`define DSPWM_ACT_B_HI 5
`define DSPWM_ACT_B_LO 4
`define DSPWM_ACT_C_HI 3
`define DSPWM_ACT_C_LO 2
`define DSPWM_MODE_LO_HI 1
`define DSPWM_MODE_HI_HI 4
`define DSPWM_MODE_HI_LO 3
`define DSPWM_PRE_HI 2

`define DSPWM_FLAG_OVF 0
`define DSPWM_FLAG_CMPA 1
`define DSPWM_FLAG_CMPB 2
`define DSPWM_FLAG_CMPC 3
`define DSPWM_FLAG_CAP 4

`define DSPWM_MODE_PFC_CAP 4'h8
`define DSPWM_MODE_PFC_CMPA 4'h9
`define DSPWM_MODE_PC_CMPA 4'hb
`define DSPWM_MODE_NORMAL 4'h0
`define DSPWM_MODE_CTC 4'h4

`define DSPWM_ACT_OFF 2'h0
`define DSPWM_ACT_TOGGLE 2'h1
`define DSPWM_ACT_NONINV 2'h2
`define DSPWM_ACT_INV 2'h3

`define DSPWM_DIV_8 11'h008
`define DSPWM_DIV_64 11'h040
`define DSPWM_DIV_256 11'h100
`define DSPWM_DIV_1024 11'h400
`define DSPWM_PRE_STOP 3'h0
`define DSPWM_PRE_1 3'h1
`define DSPWM_PRE_8 3'h2
`define DSPWM_PRE_64 3'h3
`define DSPWM_PRE_256 3'h4
`define DSPWM_PRE_1024 3'h5

`endif

// ---- tb/dspwm_properties.sv ----
// Port checker for the dual-slope PWM timer.
// Assumes it is bound to dspwm_timer, all on sys_clk.
`timescale 1ns/10ps
module dspwm_properties (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // APB.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // Pins and waveforms.
  input wire [2:0] portOut,
  input wire [2:0] waveformPinOut,
  input wire [2:0] waveformPinOe,
  input wire [2:0] waveformOutput,
  input wire timerTick
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence apbSetup(a);
    psel && !penable && paddr == a;
  endsequence
  sequence apbAccess;
    psel && !penable ##1 psel && penable;
  endsequence
  a_ready_always: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_unmapped_err: assert property (apbSetup(12'h090) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (apbSetup(12'h080) |=> !pslverr)
    else $error("control access refused");
  a_read_stands: assert property (apbAccess |=> $stable(prdata))
    else $error("read data moved after access");
  a_pin_source: assert property (((waveformPinOut ~^ waveformOutput)
    | (waveformPinOut ~^ $past(portOut))) == 3'h7)
    else $error("pin shows neither waveform nor port");
  a_wave_tick: assert property ($changed(waveformOutput) |-> $past(timerTick))
    else $error("waveform moved without tick");
  a_oe_write: assert property ($changed(waveformPinOe)
    |-> $past(psel && penable && pwrite && paddr == 12'h05c, 2))
    else $error("direction moved without write");
  a_clean_start: assert property ($fell(rst) |-> waveformOutput == 3'h0 && !timerTick)
    else $error("activity right after reset");
endmodule
bind dspwm_timer dspwm_properties chk_u (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .portOut(portOut), .waveformPinOut(waveformPinOut),
  .waveformPinOe(waveformPinOe), .waveformOutput(waveformOutput), .timerTick(timerTick));

// ---- tb/dual_slope_symmetric_pwm16_tb.sv ----
// Self-checking bench for the dual-slope PWM timer.
// Assumes the timer source and its map header on the include path.
`timescale 1ns/10ps
module dual_slope_symmetric_pwm16_tb;
  reg sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg [2:0] portOut = 3'h0;
  reg [39:0] rows [0:3];
  wire pready, pslverr, timerTick;
  wire [31:0] prdata;
  wire [2:0] pinOut, pinOe, wave;
  integer errors = 0, compares = 0, hi, per, i;
  always #10 sys_clk = ~sys_clk;
  dspwm_timer dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .portOut(portOut), .waveformPinOut(pinOut), .waveformPinOe(pinOe),
    .waveformOutput(wave), .timerTick(timerTick));
  task check(input [63:0] seen, input [63:0] exp, input [63:0] what);
    compares = compares + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("unexpected %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Period and high time of one waveform, from one rising edge to the next.
  task measure(input integer b);
    integer n;
    for (n = 0; n < 900 && wave[b] !== 1'b0; n = n + 1) @(negedge sys_clk);
    for (n = 0; n < 900 && wave[b] !== 1'b1; n = n + 1) @(negedge sys_clk);
    for (hi = 0; hi < 900 && wave[b] === 1'b1; hi = hi + 1) @(negedge sys_clk);
    for (per = hi; per < 900 && wave[b] !== 1'b1; per = per + 1) @(negedge sys_clk);
  endtask
  task stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #(20 * 20000);
    errors = errors + 1;
    stop_test;
  end
  initial
  begin
    rows[0] = {8'ha5, 32'h0000_00a5};
    rows[1] = {8'h5a, 32'hffff_ff5a};
    rows[2] = {8'hff, 32'h0000_00ff};
    rows[3] = {8'h00, 32'h1234_5600};
    repeat (12) @(posedge sys_clk);
    rst <= 0;
    apb(0, 12'h080, 0);
    check(rd, 32'h0, "ctrlrst");
    apb(0, 12'h090, 0);
    check({err, rd}, {1'b1, 32'h0}, "unmapped");
    for (i = 0; i < 4; i = i + 1)
    begin
      apb(1, 12'h080, rows[i][31:0]);
      apb(0, 12'h080, 0);
      check(rd, {24'h0, rows[i][39:32]}, "ctrlrw");
    end
    $display("register test done");
    apb(1, 12'h04c, 4);
    apb(1, 12'h050, 1);
    apb(1, 12'h054, 0);
    apb(1, 12'h05c, 7);
    apb(1, 12'h080, 8'h6d);
    apb(1, 12'h040, 5'h11);
    measure(1);
    check({hi, per}, {32'd2, 32'd8}, "noninv");
    measure(0);
    check({hi, per}, {32'd8, 32'd16}, "toggle");
    hi = 0;
    for (i = 0; i < 16; i = i + 1)
    begin
      @(negedge sys_clk);
      hi = hi + wave[2];
      check({pinOe, pinOut}, {3'h7, wave}, "pins");
    end
    check(hi, 16, "invzero");
    apb(1, 12'h058, 32'h1f);
    repeat (20) @(posedge sys_clk);
    apb(0, 12'h058, 0);
    check(rd[4:0], 5'h0f, "flags9");
    $display("mode 9 test done");
    apb(1, 12'h048, 6);
    apb(1, 12'h080, 8'h6c);
    apb(1, 12'h058, 32'h1f);
    measure(1);
    check({hi, per}, {32'd2, 32'd12}, "captop");
    apb(0, 12'h058, 0);
    check(rd[4:0], 5'h1f, "flags8");
    apb(1, 12'h040, 5'h12);
    measure(1);
    check({hi, per}, {32'd16, 32'd96}, "presc8");
    $display("mode 8 test done");
    apb(1, 12'h080, 8'h5d);
    portOut <= 3'h2;
    repeat (3) @(negedge sys_clk);
    check(pinOut[1], 1'b1, "disc1");
    portOut <= 3'h0;
    repeat (3) @(negedge sys_clk);
    check(pinOut[1], 1'b0, "disc0");
    apb(1, 12'h05c, 0);
    repeat (2) @(negedge sys_clk);
    check(pinOe, 3'h0, "diroff");
    $display("pin test done");
    @(posedge sys_clk);
    rst <= 1;
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    apb(0, 12'h080, 0);
    check({rd, wave}, 35'h0, "rerst");
    $display("second reset done");
    apb(1, 12'h04c, 4);
    apb(1, 12'h080, 8'h40);
    apb(1, 12'h040, 5'h09);
    measure(0);
    check({hi, per}, {32'd5, 32'd10}, "ctc");
    $display("compare-clear test done");
    stop_test;
  end
endmodule
